/* File: pst_stage.sv */
// pst_stage: one protection stage with pick-up, blocking and trip timing, APB registers.
// assumes magnitude, fault type and blocking input synchronous to pclk, APB master on pclk.
`timescale 1ns/1ps

// Functional notes
// (R01) pick-up asserts when magnitude passes the level, above or below per setting
// (R02) pick-up releases only when magnitude returns past 97 % of the level; in under mode the code releases at 103 %
// (R03) blocking input is sampled at the start of every program cycle
// (R04) pick-up without blocking raises start and begins the operate timing
// (R05) pick-up while blocked raises blocked and stops start and trip work
// (R06) blocking during start clears start and runs release timing
// (R07) blocking issues a display event and a stamped event with current and fault
// (R08) blocking must arrive at least 5 ms before the operate delay ends
// (R09) instant operation trips in the same cycle as start
// (R10) fixed delay trips after the set delay while pick-up holds
// (R11) inverse-time trips after a delay set by level versus magnitude
// (R12) in inverse-time the definite delay is a minimum floor, zero disables it
// (R13) delay type selects fixed or inverse counting, fixed by default
// (R14) definite delay in 5 ms steps, default 40 ms, operate time in fixed mode
// (R15) definite delay zero means instant, nonzero means fixed delay
// (R16) curve series selects between two families, first by default, inverse only; the series bit is unused and both families share the weights
// (R17) pick-up dropping before trip runs release timing, no trip
// (R18) first family offers normal, extreme, very, long and parameterised curves
// (R19) inverse delay scaled by multiplier in 10 ms steps, default 50 ms
// (R20) timers advance once per program cycle, trip when target is reached
module pst_stage #(
	parameter int TICK_CYCLES = pst_pkg::TICK_CYCLES,
	parameter int MAG_WIDTH   = 16
) (
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [7:0]            paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire logic [MAG_WIDTH-1:0]  magnitude,
	input  wire logic [3:0]            fault_type,
	input  wire logic                  block_in,
	output logic                       pickup,
	output logic                       start,
	output logic                       trip,
	output logic                       blocked,
	output logic                       display_event,
	output logic                       block_event_valid,
	output pst_pkg::pst_event_type     block_event
);
	// tick counter is 21 bits and the datapath assumes 16-bit magnitudes
	if (TICK_CYCLES < 2 || TICK_CYCLES > 2097152 || MAG_WIDTH != 16) begin : g_bad_params
		$error("pst_stage: unsupported parameter values");
	end

	// settings
	logic [5:0]  ctrl;
	logic [15:0] level;
	logic [18:0] def_delay;
	logic [11:0] mult;
	logic [15:0] rel_delay;
	logic [15:0] param_k;
	// state
	pst_pkg::pst_state_type state;
	logic [20:0] tick_cnt;
	logic        tick;
	logic [31:0] now_ms;
	logic [31:0] op_ms;
	logic [47:0] inv_acc;
	logic [15:0] rel_ms;

	// ---- APB slave: zero wait states
	logic        wr_en;
	logic        known;
	assign pready  = 1'b1;
	assign wr_en   = psel && penable && pwrite;
	assign known   = (paddr <= pst_pkg::OFS_LASTEVT) && (paddr[1:0] == 2'h0);
	assign pslverr = psel && penable && !known;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl      <= pst_pkg::RST_CTRL;
			level     <= pst_pkg::RST_PICKUP;
			def_delay <= pst_pkg::RST_DEFDLY; // [R14]
			mult      <= pst_pkg::RST_MULT; // [R19]
			rel_delay <= pst_pkg::RST_RELDLY;
			param_k   <= pst_pkg::RST_PARAMK;
		end else if (wr_en) begin
			case (paddr)
				pst_pkg::OFS_CTRL:   ctrl      <= pwdata[5:0]; // [R13] [R16]
				pst_pkg::OFS_PICKUP: level     <= pwdata[15:0];
				pst_pkg::OFS_DEFDLY: def_delay <= pwdata[18:0];
				pst_pkg::OFS_MULT:   mult      <= pwdata[11:0];
				pst_pkg::OFS_RELDLY: rel_delay <= pwdata[15:0];
				pst_pkg::OFS_PARAMK: param_k   <= pwdata[15:0];
				default: ;
			endcase
		end
	end

	always_comb begin
		case (paddr)
			pst_pkg::OFS_CTRL:    prdata = {26'h0000000, ctrl};
			pst_pkg::OFS_PICKUP:  prdata = {16'h0000, level};
			pst_pkg::OFS_DEFDLY:  prdata = {13'h0000, def_delay};
			pst_pkg::OFS_MULT:    prdata = {20'h00000, mult};
			pst_pkg::OFS_RELDLY:  prdata = {16'h0000, rel_delay};
			pst_pkg::OFS_PARAMK:  prdata = {16'h0000, param_k};
			pst_pkg::OFS_STATUS:  prdata = {25'h0000000, state, blocked, trip, start, pickup};
			pst_pkg::OFS_OPTIME:  prdata = op_ms;
			pst_pkg::OFS_LASTEVT: prdata = block_event.stamp_ms;
			default:              prdata = 32'h00000000;
		endcase
	end

	// ---- program cycle divider and millisecond time base
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_cnt <= 21'h000000;
			tick     <= 1'b0;
		end else if (tick_cnt == 21'(TICK_CYCLES - 1)) begin
			tick_cnt <= 21'h000000;
			tick     <= 1'b1;
		end else begin
			tick_cnt <= tick_cnt + 21'h000001;
			tick     <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			now_ms <= 32'h00000000;
		else if (tick)
			now_ms <= now_ms + 32'h00000001;
	end

	// ---- pick-up comparator with 97 % reset ratio, 103 % in under mode
	function automatic logic pct_below(input logic [15:0] x, input logic [15:0] ref_lvl,
			input int pct);
		pct_below = ({8'h00, x} * 24'd100) < ({8'h00, ref_lvl} * 24'(pct));
	endfunction

	logic under;
	logic next_pickup;
	assign under = ctrl[pst_pkg::CTRL_UNDER];
	always_comb begin
		if (!pickup)
			next_pickup = under ? (magnitude < level) : (magnitude > level); // [R01]
		else if (under)
			next_pickup = pct_below(magnitude, level, pst_pkg::UNDER_RATIO_PCT);
		else
			next_pickup = !pct_below(magnitude, level, pst_pkg::RESET_RATIO_PCT); // [R02]
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pickup <= 1'b0;
		else if (tick)
			pickup <= next_pickup; // [R20]
	end

	// ---- operate targets
	logic        inverse;
	logic [15:0] curve_k;
	logic [31:0] def_ms;
	logic [47:0] inv_target;
	logic [15:0] excess;
	logic [31:0] next_op_ms;
	logic [47:0] next_inv_acc;
	logic        fixed_due;
	logic        inv_due;
	logic        trip_due;
	logic        instant;
	assign inverse = ctrl[pst_pkg::CTRL_MODE]; // [R13]

	always_comb begin
		// second family shares the weights; selection only matters in inverse mode
		case (pst_pkg::pst_curve_type'(ctrl[4:2])) // [R16] [R18]
			pst_pkg::normal_inverse_curve:  curve_k = pst_pkg::K_NORMAL;
			pst_pkg::extreme_inverse_curve: curve_k = pst_pkg::K_EXTREME;
			pst_pkg::very_inverse_curve:    curve_k = pst_pkg::K_VERY;
			pst_pkg::long_inverse_curve:    curve_k = pst_pkg::K_LONG;
			pst_pkg::param_curve:           curve_k = param_k;
			default:                        curve_k = pst_pkg::K_NORMAL;
		endcase
	end

	assign def_ms     = 32'(def_delay) * 32'(pst_pkg::DEF_STEP_MS); // [R14]
	assign instant    = !inverse && (def_delay == 19'h00000); // [R15] [R09]
	// time ~ k * mult * level / excess: integrate the excess instead of dividing
	assign inv_target = 48'(curve_k) * 48'(mult) * 48'(pst_pkg::MULT_STEP_MS)
		* 48'(level); // [R11] [R19]
	// inside the reset band the excess is zero, never a wrapped difference
	assign excess     = under ? ((magnitude < level) ? (level - magnitude) : 16'h0000)
		: ((magnitude > level) ? (magnitude - level) : 16'h0000);
	assign next_op_ms   = op_ms + 32'h00000001;
	assign next_inv_acc = inv_acc + 48'(excess);
	assign fixed_due  = next_op_ms >= def_ms; // [R10] [R20]
	assign inv_due    = next_inv_acc >= inv_target;
	assign trip_due   = inverse ? (inv_due && fixed_due) : fixed_due; // [R12]

	// ---- stage state machine, evaluated once per program cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state   <= pst_pkg::ST_IDLE;
			start   <= 1'b0;
			trip    <= 1'b0;
			blocked <= 1'b0;
			op_ms   <= 32'h00000000;
			inv_acc <= 48'h000000000000;
			rel_ms  <= 16'h0000;
		end else if (tick) begin
			case (state)
				pst_pkg::ST_IDLE, pst_pkg::ST_RELEASE: begin
					if (next_pickup && block_in) begin
						state   <= pst_pkg::ST_BLOCKED; // [R05] [R03]
						blocked <= 1'b1;
						start   <= 1'b0;
					end else if (next_pickup) begin
						start   <= 1'b1; // [R04]
						blocked <= 1'b0;
						if (instant) begin
							state <= pst_pkg::ST_TRIP; // [R09]
							trip  <= 1'b1;
						end else begin
							state <= pst_pkg::ST_START;
						end
					end else if (state == pst_pkg::ST_RELEASE) begin
						// release timing: keep accumulated time until it lapses
						blocked <= 1'b0;
						if (rel_ms >= rel_delay) begin
							state   <= pst_pkg::ST_IDLE; // [R17]
							op_ms   <= 32'h00000000;
							inv_acc <= 48'h000000000000;
						end else begin
							rel_ms <= rel_ms + 16'h0001;
						end
					end
				end
				pst_pkg::ST_START: begin
					if (block_in) begin
						state   <= pst_pkg::ST_RELEASE; // [R06]
						start   <= 1'b0;
						blocked <= next_pickup;
						rel_ms  <= 16'h0000;
					end else if (!next_pickup) begin
						state  <= pst_pkg::ST_RELEASE; // [R17]
						start  <= 1'b0;
						rel_ms <= 16'h0000;
					end else begin
						op_ms   <= next_op_ms; // [R20]
						inv_acc <= next_inv_acc;
						if (trip_due) begin
							state <= pst_pkg::ST_TRIP; // [R10] [R11]
							trip  <= 1'b1;
						end
					end
				end
				pst_pkg::ST_TRIP: begin
					if (!next_pickup) begin
						state   <= pst_pkg::ST_IDLE;
						start   <= 1'b0;
						trip    <= 1'b0;
						op_ms   <= 32'h00000000;
						inv_acc <= 48'h000000000000;
					end
				end
				pst_pkg::ST_BLOCKED: begin
					// no start or trip work while blocked
					if (!block_in || !next_pickup) begin
						state   <= pst_pkg::ST_IDLE; // [R05]
						blocked <= 1'b0;
						op_ms   <= 32'h00000000;
						inv_acc <= 48'h000000000000;
					end
				end
				default: state <= pst_pkg::ST_IDLE;
			endcase
		end
	end

	// ---- blocking events
	logic blk_entry;
	assign blk_entry = tick && next_pickup && block_in && state != pst_pkg::ST_BLOCKED
		&& state != pst_pkg::ST_TRIP && !blocked;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			display_event     <= 1'b0;
			block_event_valid <= 1'b0;
			block_event       <= '0;
		end else begin
			display_event     <= blk_entry; // [R07]
			block_event_valid <= blk_entry;
			if (blk_entry) begin
				block_event.stamp_ms  <= now_ms; // [R07]
				block_event.magnitude <= magnitude;
				block_event.fault     <= fault_type;
			end
		end
	end

	// ---- assertions
	property p_trip_needs_start;
		@(posedge pclk) disable iff (!presetn) trip |-> start && !blocked;
	endproperty
	a_trip_needs_start: assert property (p_trip_needs_start) else $error("trip without start"); // [R04]

	property p_block_at_pickup;
		@(posedge pclk) disable iff (!presetn)
		tick && !pickup && next_pickup && block_in
			&& state == pst_pkg::ST_IDLE |=> blocked && !start && !trip;
	endproperty
	a_block_at_pickup: assert property (p_block_at_pickup) else $error("blocked missed"); // [R05]

	property p_start_unblocked;
		@(posedge pclk) disable iff (!presetn)
		tick && next_pickup && !block_in && state == pst_pkg::ST_IDLE |=> start;
	endproperty
	a_start_unblocked: assert property (p_start_unblocked) else $error("start missed"); // [R04]

	property p_block_clears_start;
		@(posedge pclk) disable iff (!presetn)
		tick && start && !trip && block_in |=> !start && state == pst_pkg::ST_RELEASE;
	endproperty
	a_block_clears_start: assert property (p_block_clears_start) else $error("start kept"); // [R06]

	property p_instant;
		@(posedge pclk) disable iff (!presetn)
		$rose(start) && instant |-> trip;
	endproperty
	a_instant: assert property (p_instant) else $error("instant trip late"); // [R09]

	property p_fixed_time;
		@(posedge pclk) disable iff (!presetn)
		$rose(trip) && !inverse && !instant |-> op_ms == def_ms;
	endproperty
	a_fixed_time: assert property (p_fixed_time) else $error("fixed delay wrong"); // [R10]

	property p_inv_floor;
		@(posedge pclk) disable iff (!presetn)
		$rose(trip) && inverse |-> op_ms >= def_ms && inv_acc >= inv_target;
	endproperty
	a_inv_floor: assert property (p_inv_floor) else $error("inverse trip early"); // [R12]

	property p_release_level;
		@(posedge pclk) disable iff (!presetn)
		tick && pickup && !under && magnitude >= level |=> pickup;
	endproperty
	a_release_level: assert property (p_release_level) else $error("early release"); // [R02]

	property p_block_event;
		@(posedge pclk) disable iff (!presetn)
		$rose(blocked) |-> display_event && block_event_valid;
	endproperty
	a_block_event: assert property (p_block_event) else $error("event missing"); // [R07]

	property p_tick_only;
		@(posedge pclk) disable iff (!presetn)
		!tick |=> $stable(pickup) && $stable(op_ms);
	endproperty
	a_tick_only: assert property (p_tick_only) else $error("timer off cycle"); // [R20]

	c_trip: cover property (@(posedge pclk) disable iff (!presetn) $rose(trip));
	c_blocked: cover property (@(posedge pclk) disable iff (!presetn) $rose(blocked));
	c_release: cover property (@(posedge pclk) disable iff (!presetn)
		state == pst_pkg::ST_RELEASE ##1 state == pst_pkg::ST_IDLE);
	c_inverse: cover property (@(posedge pclk) disable iff (!presetn) $rose(trip) && inverse);
endmodule : pst_stage

/* File: pst_pkg.sv */
// pst_pkg: constants, register map, field layouts and types of the protection stage.
// assumes a 100 MHz pclk and one program cycle per millisecond.
package pst_pkg;
	// clock and program cycle
	localparam int CLK_MHZ          = 100;
	localparam int PROGRAM_CYCLE_US = 1000;
	localparam int TICK_CYCLES      = PROGRAM_CYCLE_US * CLK_MHZ;
	// delay settings: definite in 5 ms steps, multiplier in 10 ms steps
	localparam int DEF_STEP_MS      = 5;
	localparam int MULT_STEP_MS     = 10;
	localparam int RESET_RATIO_PCT  = 97;
	localparam int UNDER_RATIO_PCT  = 103;
	// register byte offsets
	localparam logic [7:0] OFS_CTRL    = 8'h00;
	localparam logic [7:0] OFS_PICKUP  = 8'h04;
	localparam logic [7:0] OFS_DEFDLY  = 8'h08;
	localparam logic [7:0] OFS_MULT    = 8'h0C;
	localparam logic [7:0] OFS_RELDLY  = 8'h10;
	localparam logic [7:0] OFS_PARAMK  = 8'h14;
	localparam logic [7:0] OFS_STATUS  = 8'h18;
	localparam logic [7:0] OFS_OPTIME  = 8'h1C;
	localparam logic [7:0] OFS_LASTEVT = 8'h20;
	// control field positions
	localparam int CTRL_MODE   = 0;
	localparam int CTRL_SERIES = 1;
	localparam int CTRL_CURVE  = 2;
	localparam int CTRL_UNDER  = 5;
	// reset values
	localparam logic [5:0]  RST_CTRL   = 6'h00;
	localparam logic [15:0] RST_PICKUP = 16'h0100;
	localparam logic [18:0] RST_DEFDLY = 19'h00008;
	localparam logic [11:0] RST_MULT   = 12'h005;
	localparam logic [15:0] RST_RELDLY = 16'h0000;
	localparam logic [15:0] RST_PARAMK = 16'h0020;
	// inverse-time weights per curve, in ms per unit of pick-up (plain defaults)
	localparam logic [15:0] K_NORMAL  = 16'h0014;
	localparam logic [15:0] K_EXTREME = 16'h0050;
	localparam logic [15:0] K_VERY    = 16'h0028;
	localparam logic [15:0] K_LONG    = 16'h0078;

	typedef enum logic [2:0] {
		normal_inverse_curve  = 3'h0,
		extreme_inverse_curve = 3'h1,
		very_inverse_curve    = 3'h2,
		long_inverse_curve    = 3'h3,
		param_curve           = 3'h4
	} pst_curve_type;

	typedef enum logic [2:0] {
		ST_IDLE    = 3'h0,
		ST_START   = 3'h1,
		ST_TRIP    = 3'h2,
		ST_BLOCKED = 3'h3,
		ST_RELEASE = 3'h4
	} pst_state_type;

	typedef struct packed {
		logic [31:0] stamp_ms;
		logic [15:0] magnitude;
		logic [3:0]  fault;
	} pst_event_type;
endpackage : pst_pkg

/* File: pst_block_src.sv */
// pst_block_src: model of the blocking matrix feeding the stage's blocking input.
// assumes the bench raises req early enough; the model adds only routing lag.
`timescale 1ns/1ps
module pst_block_src #(
	parameter int LAG = 3
) (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic req,
	output logic      block_in
);
	int cnt;

	// matrix signals are clean levels; the lag mimics routing through the matrix
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt      <= 0;
			block_in <= 1'b0;
		end else if (req != block_in && cnt < LAG) begin
			cnt <= cnt + 1;
		end else begin
			cnt      <= 0;
			block_in <= req;
		end
	end
endmodule : pst_block_src

/* File: tb.sv */
// tb: random and corner-case bench for the protection stage over APB.
// assumes pst_stage and the blocking source model; program tick shortened to TK.
`timescale 1ns/1ps
module tb;
	localparam int TK = 4;
	logic                   pclk = 0;
	logic                   presetn = 0;
	logic                   psel = 0;
	logic                   penable = 0;
	logic                   pwrite = 0;
	logic [7:0]             paddr = 8'h00;
	logic [31:0]            pwdata = 32'h0;
	logic [31:0]            prdata;
	logic                   pready;
	logic                   pslverr;
	logic [15:0]            magnitude = 16'h0000;
	logic [3:0]             fault_type = 4'h0;
	logic                   blk_req = 0;
	logic                   block_in, pickup, start, trip, blocked;
	logic                   display_event, block_event_valid;
	pst_pkg::pst_event_type block_event;
	pst_pkg::pst_event_type ev;
	logic [31:0]            rd;
	logic                   err;
	int                     fails = 0;
	int                     checks = 0;
	int                     nevt = 0;
	int                     cyc, cyc2, k, c, n0;
	logic [15:0]            m;
	logic [7:0]             ofs [4];
	logic [31:0]            rv [4];
	int                     kw [5];

	always #5 pclk = ~pclk;

	pst_stage #(.TICK_CYCLES(TK), .MAG_WIDTH(16)) dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .magnitude(magnitude),
		.fault_type(fault_type), .block_in(block_in), .pickup(pickup), .start(start),
		.trip(trip), .blocked(blocked), .display_event(display_event),
		.block_event_valid(block_event_valid), .block_event(block_event));

	pst_block_src #(.LAG(3)) blk (.pclk(pclk), .presetn(presetn), .req(blk_req),
		.block_in(block_in));

	always @(posedge pclk) begin
		if (presetn && block_event_valid === 1'b1) begin
			nevt++;
			ev = block_event;
		end
		if (presetn && display_event !== block_event_valid) fail("event pulses apart");
	end

	task automatic fail(input string msg);
		fails++;
		$display("[FAIL] %0t %s", $time, msg);
	endtask : fail

	task automatic report_and_stop;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : report_and_stop

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		checks++;
		if (got !== exp) fail(msg);
	endtask : chk

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		rd  = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (i == 20) begin
			fail("apb hang");
			report_and_stop();
		end
	endtask : apb

	function automatic logic pick(input int s);
		case (s)
			0: return pickup;
			1: return start;
			2: return trip;
			3: return blocked;
			default: return block_in;
		endcase
	endfunction : pick

	// cycles counted from the call until the watched output reaches v
	task automatic wait_on(input int s, input logic v, input int lim, output int n);
		n = 0;
		while (pick(s) !== v && n < lim) begin
			@(posedge pclk);
			#1;
			n++;
		end
		if (pick(s) !== v) begin
			fail("wait timed out");
			report_and_stop();
		end
	endtask : wait_on

	task automatic drive(input logic [15:0] mv, input logic b);
		@(posedge pclk);
		magnitude  <= mv;
		blk_req    <= b;
		fault_type <= 4'($urandom_range(1, 15));
	endtask : drive

	task automatic do_reset;
		drive(16'h0000, 1'b0);
		presetn <= 1'b0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
	endtask : do_reset

	task automatic quiet(input int len, output int n);
		n = 0;
		repeat (len) begin
			@(posedge pclk);
			#1;
			if (trip !== 1'b0) n++;
		end
	endtask : quiet

	// start to trip time, then pick-up dropped again
	task automatic measure(input logic [15:0] mv, output int n);
		int s;
		drive(mv, 1'b0);
		wait_on(1, 1'b1, 2000, s);
		wait_on(2, 1'b1, 2000, n);
		drive(16'h0000, 1'b0);
		wait_on(0, 1'b0, 8 * TK, s);
	endtask : measure

	// inverse trip time in cycles with multiplier 1: ceil(weight * step * level / excess) times TK
	function automatic int inv_ticks(input int w, input int lvl, input int mag);
		int tgt;
		tgt = w * pst_pkg::MULT_STEP_MS * lvl;
		return (tgt + mag - lvl - 1) / (mag - lvl) * TK;
	endfunction : inv_ticks

	initial begin
		ofs = '{pst_pkg::OFS_CTRL, pst_pkg::OFS_PICKUP, pst_pkg::OFS_DEFDLY, pst_pkg::OFS_MULT};
		rv  = '{32'h0, 32'h100, 40 / pst_pkg::DEF_STEP_MS, 50 / pst_pkg::MULT_STEP_MS};
		kw  = '{pst_pkg::K_NORMAL, pst_pkg::K_EXTREME, pst_pkg::K_VERY, pst_pkg::K_LONG,
			pst_pkg::RST_PARAMK};
		void'($urandom(32'hF9B3));
		do_reset();
		for (k = 0; k < 4; k++) begin
			apb(1'b0, ofs[k], 32'h0);
			chk(rd, rv[k], "reset value");
		end
		apb(1'b1, 8'h24, 32'h1);
		chk({31'h0, err}, 32'h1, "unmapped write accepted");
		apb(1'b0, 8'h24, 32'h0);
		chk({31'h0, err}, 32'h1, "unmapped read accepted");
		$display("test registers done");

		c = $urandom_range(1, 3);
		apb(1'b1, pst_pkg::OFS_DEFDLY, c);
		m = 16'h0100 + 16'($urandom_range(16, 400));
		drive(m, 1'b0);
		wait_on(1, 1'b1, 8 * TK, cyc);
		drive(16'h0000, 1'b0);
		quiet(5 * c * TK + 4 * TK, cyc);
		chk(cyc, 0, "trip after early drop");
		measure(m, cyc);
		chk(cyc, 5 * c * TK, "fixed delay time");
		$display("test fixed delay done");

		do_reset();
		apb(1'b1, pst_pkg::OFS_DEFDLY, 32'h0);
		drive(16'h0180, 1'b0);
		wait_on(1, 1'b1, 8 * TK, cyc);
		chk({31'h0, trip}, 32'h1, "instant trip late");
		drive(16'd250, 1'b0);
		quiet(3 * TK, cyc);
		chk({31'h0, pickup}, 32'h1, "released above reset ratio");
		apb(1'b0, pst_pkg::OFS_STATUS, 32'h0);
		chk({29'h0, rd[2:0]}, 32'h7, "status flags");
		drive(16'd240, 1'b0);
		wait_on(0, 1'b0, 3 * TK, cyc);
		$display("test instant and release done");

		do_reset();
		n0 = nevt;
		drive(16'h0000, 1'b1);
		wait_on(4, 1'b1, 20, cyc);
		m = 16'h0100 + 16'($urandom_range(16, 400));
		drive(m, 1'b1);
		wait_on(3, 1'b1, 3 * TK, cyc);
		quiet(50 * TK, cyc);
		chk(cyc, 0, "blocked stage tripped");
		chk({31'h0, start}, 32'h0, "blocked stage started");
		chk(nevt - n0, 1, "block event count");
		chk(ev.magnitude, m, "event magnitude");
		chk(ev.fault, fault_type, "event fault");
		drive(16'h0000, 1'b0);
		wait_on(0, 1'b0, 3 * TK, cyc);
		drive(m, 1'b0);
		wait_on(1, 1'b1, 3 * TK, cyc);
		drive(m, 1'b1); // lead far above 5 program cycles
		wait_on(1, 1'b0, 8 * TK, cyc);
		quiet(50 * TK, cyc);
		chk(cyc, 0, "trip after block in start");
		chk(nevt - n0, 2, "second block event");
		apb(1'b0, pst_pkg::OFS_LASTEVT, 32'h0);
		chk(rd, ev.stamp_ms, "event stamp register");
		$display("test blocking done");

		do_reset();
		apb(1'b1, pst_pkg::OFS_PICKUP, 32'h40);
		apb(1'b1, pst_pkg::OFS_MULT, 32'h1);
		apb(1'b1, pst_pkg::OFS_DEFDLY, 32'h0);
		for (k = 0; k < 5; k++) begin
			apb(1'b1, pst_pkg::OFS_CTRL, {k[2:0], 1'($urandom_range(0, 1)), 1'b1});
			measure(16'h0540, cyc);
			measure(16'h02C0, cyc2);
			chk(32'(cyc2 > cyc), 32'h1, "inverse time order");
			chk(cyc, inv_ticks(kw[k], 32'h40, 32'h540), "inverse time high");
			chk(cyc2, inv_ticks(kw[k], 32'h40, 32'h2C0), "inverse time low");
		end
		apb(1'b1, pst_pkg::OFS_CTRL, 32'h1);
		apb(1'b1, pst_pkg::OFS_DEFDLY, 32'h8);
		measure(16'h0540, cyc);
		chk(32'(cyc < 40 * TK), 32'h0, "minimum time floor");
		$display("test inverse time done");

		do_reset();
		drive(16'h0100, 1'b0);
		apb(1'b1, pst_pkg::OFS_DEFDLY, 32'h0);
		apb(1'b1, pst_pkg::OFS_CTRL, 32'h20);
		drive(16'h0080, 1'b0);
		wait_on(2, 1'b1, 8 * TK, cyc);
		drive(16'h0102, 1'b0);
		quiet(3 * TK, cyc);
		chk({31'h0, pickup}, 32'h1, "under mode released early");
		drive(16'h0110, 1'b0);
		wait_on(0, 1'b0, 3 * TK, cyc);

		do_reset();
		apb(1'b1, pst_pkg::OFS_RELDLY, 32'h14);
		for (k = 0; k < 2; k++) begin
			drive(16'h0200, 1'b0);
			wait_on(1, 1'b1, 8 * TK, cyc);
			quiet(10 * TK, cyc);
			chk(cyc, 0, "trip before delay");
			drive(16'h0000, 1'b0);
			wait_on(1, 1'b0, 3 * TK, cyc);
			apb(1'b0, pst_pkg::OFS_OPTIME, 32'h0);
			chk(32'(rd != 32'h0), 32'h1, "release lost time");
			if (k == 0) begin
				quiet(25 * TK, cyc);
				apb(1'b0, pst_pkg::OFS_OPTIME, 32'h0);
				chk(rd, 32'h0, "release never lapsed");
			end
		end
		measure(16'h0200, cyc);
		chk(32'(cyc < 40 * TK), 32'h1, "release did not resume");
		$display("test under mode and release done");
		report_and_stop();
	end
endmodule : tb
